// ### rtl/pin_seven_control.sv
// Control, role selection and interrupt logic of general-purpose pin seven.
//
// Contract
// - Bit 15 direction: 0 output, 1 input, reset 1.
// - Pull field: none, down, up; reset pull-down.
// - Single edge by polarity, or both edges.
// - Polarity bit 10: 0 inverted, reset 1.
// - Bit 9: push-pull or open-drain, reset 0.
// - Bit 7 enable: 0 tri-states pin, reset 0.
// - Bit 11 chooses the pin supply domain.
// - Function field; inputs 0 and 1 plain.
// - Input codes 2 to 6 are power requests.
// - Inputs 7 watchdog, 8 and 9 scaling selects.
// - Inputs 10 to 15 hardware enables and controls.
// - Output 0 register level, 1 slow clock.
// - Outputs 2 to 4 states; 5 to 7 reserved.
// - Outputs 10 and 11 external power enables.
// - Outputs 12 and 13 supply and power good.
// - Output 14 fast clock, 15 auxiliary reset.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps

module pin_seven_control #(
    parameter logic [19:0] DEBOUNCE_CYCLES = 20'h0f424
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [31:0]              wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     pad_in_i,
    output logic                          pad_out_o,
    output logic                          pad_oe_o,
    output logic                          pull_up_o,
    output logic                          pull_down_o,
    output logic                          supply_domain_o,
    input  wire pin_seven_pkg::out_src_t  src_i,
    output pin_seven_pkg::in_roles_t      roles_o,
    output logic                          irq_o
);

    // One-hot form of a function code; used for roles and for debounce.
    function automatic logic [15:0] fn_onehot(input logic [3:0] code);
        fn_onehot = 16'h0001 << code;
    endfunction

    // Register state and next values.
    pin_seven_pkg::ctrl_t ctrl_reg;      // Control register.
    pin_seven_pkg::ctrl_t ctrl_next;
    logic                 data_out_reg;  // Level for the plain output role.
    logic                 data_out_next;
    logic                 irq_stat_reg;  // Sticky pin edge event.
    logic                 irq_stat_next;
    logic                 irq_en_reg;    // Enable of the pin edge event.
    logic                 irq_en_next;
    logic                 ack_reg;       // Wishbone acknowledge.
    logic [31:0]          rdat_reg;      // Registered read data.
    logic [31:0]          rdat_next;

    // Pin input path state.
    logic [2:0]           sync_reg;      // Three-stage synchroniser.
    logic                 stable_reg;    // Level once stages two and three agree.
    logic                 stable_next;
    logic                 deb_reg;       // Debounced pin level.
    logic                 deb_next;
    logic [19:0]          deb_cnt_reg;   // Long debounce counter.
    logic [19:0]          deb_cnt_next;

    // Pin output path and role state.
    logic                 pad_out_reg;
    logic                 pad_oe_reg;
    pin_seven_pkg::in_roles_t roles_reg;
    pin_seven_pkg::in_roles_t roles_next;

    // Bus decode wires.
    wire logic [29:0] word_adr = wb_adr_i[31:2];
    wire logic        req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire logic        wr       = req & wb_we_i;
    wire logic        hit_ctrl = word_adr == pin_seven_pkg::CTRL_IDX;
    wire logic        hit_data = word_adr == pin_seven_pkg::DATA_IDX;
    wire logic        hit_stat = word_adr == pin_seven_pkg::IRQ_STAT_IDX;
    wire logic        hit_clr  = word_adr == pin_seven_pkg::IRQ_CLR_IDX;
    wire logic        hit_en   = word_adr == pin_seven_pkg::IRQ_EN_IDX;

    // Byte lanes of the 16-bit control register, limited to writable bits.
    wire logic [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} &
                              pin_seven_pkg::CTRL_RW_MASK;

    // Role selection wires.
    wire logic [15:0] fn_sel   = fn_onehot(ctrl_reg.pin_function);
    wire logic        is_input = ctrl_reg.pin_direction;
    wire logic        drives   = ~ctrl_reg.pin_direction &
                                 ctrl_reg.pin_enable;
    wire logic        listens  = is_input & ctrl_reg.pin_enable;
    // Long debounce for input codes 0, 4, 14 and 15 only.
    wire logic        long_deb = is_input &
                                 (|(fn_sel & pin_seven_pkg::LONG_DEB_MASK));
    // Input level as software and the roles see it.
    wire logic        logical_in = ctrl_reg.pin_polarity ?
                                   deb_reg : ~deb_reg;

    // Edge detection on the debounced level only.
    wire logic        rise = deb_next & ~deb_reg;
    wire logic        fall = ~deb_next & deb_reg;
    wire logic        edge_evt = listens & (ctrl_reg.irq_edge_mode ?
                                 (rise | fall) :
                                 (ctrl_reg.pin_polarity ? rise : fall));

    // Interrupt clear strobe from the write-only clear register.
    wire logic        irq_clr = wr & hit_clr & wb_sel_i[0] &
                                wb_dat_i[pin_seven_pkg::IRQ_EDGE_BIT];

    // Source vector indexed by output function code.
    logic [15:0] src_vec;

    // Build the output source vector; reserved codes carry zero.
    always_comb begin
        src_vec = 16'h0000;
        src_vec[pin_seven_pkg::FN_OUT_GPIO]    = data_out_reg;
        src_vec[pin_seven_pkg::FN_OUT_CLK32K]  = src_i.clk_32k;
        src_vec[pin_seven_pkg::FN_OUT_ON]      = src_i.on_state;
        src_vec[pin_seven_pkg::FN_OUT_SLEEP]   = src_i.sleep_state;
        src_vec[pin_seven_pkg::FN_OUT_CHANGE]  = src_i.state_change;
        src_vec[pin_seven_pkg::FN_OUT_DONE1]   = src_i.dvs_done_one;
        src_vec[pin_seven_pkg::FN_OUT_DONE2]   = src_i.dvs_done_two;
        src_vec[pin_seven_pkg::FN_OUT_EXTEN1]  =
            src_i.ext_power_enable_one;
        src_vec[pin_seven_pkg::FN_OUT_EXTEN2]  =
            src_i.ext_power_enable_two;
        src_vec[pin_seven_pkg::FN_OUT_SYSGOOD] =
            src_i.system_supply_good;
        src_vec[pin_seven_pkg::FN_OUT_PWRGOOD] =
            src_i.converter_power_good;
        src_vec[pin_seven_pkg::FN_OUT_CLK2M]   = src_i.clk_2m;
        src_vec[pin_seven_pkg::FN_OUT_AUXRST]  = src_i.aux_reset;
    end

    // Output level after polarity; inactive means logical zero.
    wire logic active    = src_vec[ctrl_reg.pin_function];
    wire logic pin_level = ctrl_reg.pin_polarity ? active : ~active;
    // Open drain only pulls low and lets the pull or the board raise it.
    wire logic oe_next   = drives & (~ctrl_reg.drive_type | ~pin_level);

    // Register write path with byte lanes and reserved bits held at zero.
    always_comb begin
        ctrl_next     = ctrl_reg;
        data_out_next = data_out_reg;
        irq_en_next   = irq_en_reg;
        if (wr & hit_ctrl) begin
            ctrl_next = (ctrl_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
        end else if (wr & hit_data & wb_sel_i[0]) begin
            data_out_next = wb_dat_i[pin_seven_pkg::DATA_OUT_BIT];
        end else if (wr & hit_en & wb_sel_i[0]) begin
            irq_en_next = wb_dat_i[pin_seven_pkg::IRQ_EDGE_BIT];
        end
    end

    // A new edge in the same cycle as a clear keeps the flag set.
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | edge_evt;

    // Read mux; unmapped and write-only addresses read as zero.
    always_comb begin
        rdat_next = 32'h00000000;
        if (hit_ctrl) begin
            rdat_next[15:0] = ctrl_reg & pin_seven_pkg::CTRL_RW_MASK;
        end else if (hit_data) begin
            rdat_next[pin_seven_pkg::DATA_OUT_BIT] = data_out_reg;
            rdat_next[pin_seven_pkg::DATA_IN_BIT]  = logical_in;
        end else if (hit_stat) begin
            rdat_next[pin_seven_pkg::IRQ_EDGE_BIT] = irq_stat_reg;
        end else if (hit_en) begin
            rdat_next[pin_seven_pkg::IRQ_EDGE_BIT] = irq_en_reg;
        end
    end

    // A change counts once stages two and three agree.
    assign stable_next = (sync_reg[1] == sync_reg[2]) ?
                         sync_reg[2] : stable_reg;

    // Long debounce waits for the level to stay put for the full count.
    always_comb begin
        deb_next     = deb_reg;
        deb_cnt_next = 20'h00000;
        if (!long_deb) begin
            deb_next = stable_reg;
        end else if (stable_reg != deb_reg) begin
            if (deb_cnt_reg >= DEBOUNCE_CYCLES - 20'h00001) begin
                deb_next = stable_reg;
            end else begin
                deb_cnt_next = deb_cnt_reg + 20'h00001;
            end
        end
    end

    // Hand the debounced level to the selected input role only.
    always_comb begin
        roles_next = '0;
        if (listens) begin
            roles_next.power_onoff_req =
                fn_sel[pin_seven_pkg::FN_IN_ONOFF] & logical_in;
            roles_next.sleep_wake_req =
                (fn_sel[pin_seven_pkg::FN_IN_SLPWAKE] |
                 fn_sel[pin_seven_pkg::FN_IN_SLPWAKEL]) & logical_in;
            roles_next.sleep_req =
                fn_sel[pin_seven_pkg::FN_IN_SLEEP] & logical_in;
            roles_next.power_on_req =
                fn_sel[pin_seven_pkg::FN_IN_PWRON] & logical_in;
            roles_next.watchdog_reset =
                fn_sel[pin_seven_pkg::FN_IN_WDOG] & logical_in;
            roles_next.voltage_scaling_select_one =
                fn_sel[pin_seven_pkg::FN_IN_VSEL1] & logical_in;
            roles_next.voltage_scaling_select_two =
                fn_sel[pin_seven_pkg::FN_IN_VSEL2] & logical_in;
            roles_next.hw_enable_one =
                fn_sel[pin_seven_pkg::FN_IN_HWEN1] & logical_in;
            roles_next.hw_enable_two =
                fn_sel[pin_seven_pkg::FN_IN_HWEN2] & logical_in;
            roles_next.hw_control_one =
                (fn_sel[pin_seven_pkg::FN_IN_HWCTL1] |
                 fn_sel[pin_seven_pkg::FN_IN_HWCTL1L]) & logical_in;
            roles_next.hw_control_two =
                (fn_sel[pin_seven_pkg::FN_IN_HWCTL2] |
                 fn_sel[pin_seven_pkg::FN_IN_HWCTL2L]) & logical_in;
        end
    end

    // Software registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg     <= pin_seven_pkg::CTRL_RESET;
            data_out_reg <= 1'b0;
            irq_stat_reg <= 1'b0;
            irq_en_reg   <= 1'b0;
        end else if (ce_i) begin
            ctrl_reg     <= ctrl_next;
            data_out_reg <= data_out_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg   <= irq_en_next;
        end
    end

    // Bus answer one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else if (ce_i) begin
            ack_reg  <= req;
            rdat_reg <= req ? rdat_next : rdat_reg;
        end
    end

    // Synchroniser; only stage two reads stage one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg   <= 3'h0;
            stable_reg <= 1'b0;
        end else if (ce_i) begin
            sync_reg   <= {sync_reg[1:0], pad_in_i};
            stable_reg <= stable_next;
        end
    end

    // Debounce state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deb_reg     <= 1'b0;
            deb_cnt_reg <= 20'h00000;
        end else if (ce_i) begin
            deb_reg     <= deb_next;
            deb_cnt_reg <= deb_cnt_next;
        end
    end

    // Registered pad and role outputs avoid glitches.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_reg <= 1'b0;
            pad_oe_reg  <= 1'b0;
            roles_reg   <= '0;
        end else if (ce_i) begin
            pad_out_reg <= pin_level & ~ctrl_reg.drive_type;
            pad_oe_reg  <= oe_next;
            roles_reg   <= roles_next;
        end
    end

    // Output assignments.
    assign wb_ack_o        = ack_reg;
    assign wb_dat_o        = rdat_reg;
    assign pad_out_o       = pad_out_reg;
    assign pad_oe_o        = pad_oe_reg;
    assign roles_o         = roles_reg;
    assign pull_up_o       = ctrl_reg.pull_select == pin_seven_pkg::PULL_UP;
    assign pull_down_o     = ctrl_reg.pull_select == pin_seven_pkg::PULL_DOWN;
    assign supply_domain_o = ctrl_reg.supply_domain_select;
    assign irq_o           = irq_stat_reg & irq_en_reg;

endmodule

// ### include/pin_seven_pkg.sv
// Package with register map, field layout and codes of the pin seven block.
package pin_seven_pkg;

    // Register word indices; byte address is four times these.
    localparam logic [29:0] CTRL_IDX     = 30'h0000403e;
    localparam logic [29:0] DATA_IDX     = 30'h00004100;
    localparam logic [29:0] IRQ_STAT_IDX = 30'h00004101;
    localparam logic [29:0] IRQ_CLR_IDX  = 30'h00004102;
    localparam logic [29:0] IRQ_EN_IDX   = 30'h00004103;

    // Control reset value: input, pull-down, active high, tri-stated.
    localparam logic [15:0] CTRL_RESET   = 16'ha400;
    // Writable control bits; bits 8 and 6:4 are reserved and read zero.
    localparam logic [15:0] CTRL_RW_MASK = 16'hfe8f;

    // Pull field codes.
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;

    // Input codes that ask for the long debounce, as a one-hot mask.
    localparam logic [15:0] LONG_DEB_MASK = 16'hc011;

    // Input function codes.
    localparam logic [3:0] FN_IN_ONOFF    = 4'h2;
    localparam logic [3:0] FN_IN_SLPWAKE  = 4'h3;
    localparam logic [3:0] FN_IN_SLPWAKEL = 4'h4;
    localparam logic [3:0] FN_IN_SLEEP    = 4'h5;
    localparam logic [3:0] FN_IN_PWRON    = 4'h6;
    localparam logic [3:0] FN_IN_WDOG     = 4'h7;
    localparam logic [3:0] FN_IN_VSEL1    = 4'h8;
    localparam logic [3:0] FN_IN_VSEL2    = 4'h9;
    localparam logic [3:0] FN_IN_HWEN1    = 4'ha;
    localparam logic [3:0] FN_IN_HWEN2    = 4'hb;
    localparam logic [3:0] FN_IN_HWCTL1   = 4'hc;
    localparam logic [3:0] FN_IN_HWCTL2   = 4'hd;
    localparam logic [3:0] FN_IN_HWCTL1L  = 4'he;
    localparam logic [3:0] FN_IN_HWCTL2L  = 4'hf;

    // Output function codes; 5 to 7 are reserved.
    localparam logic [3:0] FN_OUT_GPIO    = 4'h0;
    localparam logic [3:0] FN_OUT_CLK32K  = 4'h1;
    localparam logic [3:0] FN_OUT_ON      = 4'h2;
    localparam logic [3:0] FN_OUT_SLEEP   = 4'h3;
    localparam logic [3:0] FN_OUT_CHANGE  = 4'h4;
    localparam logic [3:0] FN_OUT_RSV5    = 4'h5;
    localparam logic [3:0] FN_OUT_RSV6    = 4'h6;
    localparam logic [3:0] FN_OUT_RSV7    = 4'h7;
    localparam logic [3:0] FN_OUT_DONE1   = 4'h8;
    localparam logic [3:0] FN_OUT_DONE2   = 4'h9;
    localparam logic [3:0] FN_OUT_EXTEN1  = 4'ha;
    localparam logic [3:0] FN_OUT_EXTEN2  = 4'hb;
    localparam logic [3:0] FN_OUT_SYSGOOD = 4'hc;
    localparam logic [3:0] FN_OUT_PWRGOOD = 4'hd;
    localparam logic [3:0] FN_OUT_CLK2M   = 4'he;
    localparam logic [3:0] FN_OUT_AUXRST  = 4'hf;

    // Bits of the data register and of the interrupt registers.
    localparam int unsigned DATA_OUT_BIT = 0;
    localparam int unsigned DATA_IN_BIT  = 1;
    localparam int unsigned IRQ_EDGE_BIT = 0;

    // Control register layout, MSB first.
    typedef struct packed {
        logic       pin_direction;        // 1 = input, 0 = output.
        logic [1:0] pull_select;          // Pull resistor choice.
        logic       irq_edge_mode;        // 1 = both edges.
        logic       supply_domain_select; // 1 = always-on supply.
        logic       pin_polarity;         // 1 = active high.
        logic       drive_type;           // 1 = open drain.
        logic       rsv8;                 // Reserved.
        logic       pin_enable;           // 0 = tri-stated.
        logic [2:0] rsv6_4;               // Reserved.
        logic [3:0] pin_function;         // Role of the pin.
    } ctrl_t;

    // Levels an input role hands on.
    typedef struct packed {
        logic power_onoff_req;
        logic sleep_wake_req;
        logic sleep_req;
        logic power_on_req;
        logic watchdog_reset;
        logic voltage_scaling_select_one;
        logic voltage_scaling_select_two;
        logic hw_enable_one;
        logic hw_enable_two;
        logic hw_control_one;
        logic hw_control_two;
    } in_roles_t;

    // Sources an output role can drive.
    typedef struct packed {
        logic clk_32k;
        logic on_state;
        logic sleep_state;
        logic state_change;
        logic dvs_done_one;
        logic dvs_done_two;
        logic ext_power_enable_one;
        logic ext_power_enable_two;
        logic system_supply_good;
        logic converter_power_good;
        logic clk_2m;
        logic aux_reset;
    } out_src_t;

endpackage

// ### testbench/pin_seven_sva.sv
// Checker of bus, pad and role behaviour at the pin seven ports.
`timescale 1ns/1ps
module pin_seven_sva (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     ce_i,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [31:0]              wb_adr_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic                     wb_ack_o,
    input wire logic                     pad_out_o,
    input wire logic                     pad_oe_o,
    input wire logic                     pull_up_o,
    input wire logic                     pull_down_o,
    input wire logic                     supply_domain_o,
    input wire pin_seven_pkg::out_src_t  src_i,
    input wire pin_seven_pkg::in_roles_t roles_o,
    input wire logic                     irq_o
);
    pin_seven_pkg::ctrl_t sh;  // Shadow of the control register.
    logic [1:0]           cnt; // Edges since the last control write, held at two.
    logic [15:0]          src_v; // Sources indexed by function code.
    wire logic take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i
        && (wb_adr_i[31:2] == pin_seven_pkg::CTRL_IDX);
    wire logic [15:0] wr_v = {wb_sel_i[1] ? wb_dat_i[15:8] : sh[15:8],
                              wb_sel_i[0] ? wb_dat_i[7:0] : sh[7:0]};
    // Outputs lag a stage; checks wait two edges.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh  <= pin_seven_pkg::CTRL_RESET;
            cnt <= 2'h0;
        end else if (take) begin
            sh  <= wr_v & pin_seven_pkg::CTRL_RW_MASK;
            cnt <= 2'h0;
        end else if (cnt != 2'h2) begin
            cnt <= cnt + 2'h1;
        end
    end
    wire logic ok = (cnt == 2'h2);
    // Code 0 and reserved 5 to 7 carry no source.
    assign src_v = {src_i.aux_reset, src_i.clk_2m,
        src_i.converter_power_good, src_i.system_supply_good,
        src_i.ext_power_enable_two, src_i.ext_power_enable_one,
        src_i.dvs_done_two, src_i.dvs_done_one, 3'h0, src_i.state_change,
        src_i.sleep_state, src_i.on_state, src_i.clk_32k, 1'b0};
    wire logic pick = src_v[sh.pin_function];
    wire logic outp = ok && !sh.pin_direction && sh.pin_enable;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_rst; $fell(rst_i) |-> !pad_oe_o && pull_down_o && !irq_o; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    property p_in; ok && sh.pin_direction |-> !pad_oe_o; endproperty
    a_in: assert property (p_in) else $error("input pin driven");
    property p_tri; ok && !sh.pin_enable |-> !pad_oe_o; endproperty
    a_tri: assert property (p_tri) else $error("disabled pin driven");
    property p_pull; ok && sh.pull_select != 2'h3 |->
        pull_up_o == sh.pull_select[1] && pull_down_o == sh.pull_select[0];
    endproperty
    a_pull: assert property (p_pull) else $error("pull mismatch");
    property p_dom; ok |-> supply_domain_o == sh.supply_domain_select; endproperty
    a_dom: assert property (p_dom) else $error("domain mismatch");
    property p_od; outp && sh.drive_type |-> !pad_out_o; endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_map; outp && !sh.drive_type && sh.pin_function != 4'h0 |-> pad_oe_o && (pad_out_o == ($past(pick) ^ !sh.pin_polarity)); endproperty
    a_map: assert property (p_map) else $error("output role wrong");
    property p_roff; ok && !(sh.pin_direction && sh.pin_enable) |-> roles_o == '0; endproperty
    a_roff: assert property (p_roff) else $error("role while not input");
    c_take: cover property (take);
    c_irq: cover property ($rose(irq_o));
    c_od: cover property (outp && sh.drive_type && !pad_oe_o);
endmodule

// ### testbench/pin_seven_board.sv
// Model of the board at pin seven: a peer driver and the pull resistors.
`timescale 1ns/1ps
module pin_seven_board (
    input  wire logic clk_i,
    input  wire logic pad_out_i,
    input  wire logic pad_oe_i,
    input  wire logic pull_up_i,
    input  wire logic pull_down_i,
    input  wire logic peer_oe_i,
    input  wire logic peer_val_i,
    output logic      level_o
);
    logic last = 1'b0; // Wire level seen at the previous edge.
    // A floating wire shows the inverse of its last level.
    always_comb begin
        if (pad_oe_i) begin
            level_o = pad_out_i;
        end else if (peer_oe_i) begin
            level_o = peer_val_i;
        end else if (pull_up_i || pull_down_i) begin
            level_o = pull_up_i;
        end else begin
            level_o = !last;
        end
    end
    always_ff @(posedge clk_i) begin
        last <= level_o;
    end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the pin seven control block.
`timescale 1ns/1ps
module tb_top;
    localparam CTL = pin_seven_pkg::CTRL_IDX;
    localparam DAT = pin_seven_pkg::DATA_IDX;
    localparam STA = pin_seven_pkg::IRQ_STAT_IDX;
    localparam CLR = pin_seven_pkg::IRQ_CLR_IDX;
    localparam ENA = pin_seven_pkg::IRQ_EN_IDX;
    // Bit of the role vector that each input code raises.
    localparam int RB[16] = '{0, 0, 10, 9, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 1, 0};
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        peer_oe = 1'b0, peer_val = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, q;
    pin_seven_pkg::out_src_t       src = '0;
    wire logic [31:0]              rdat;
    wire logic                     ack, pin, pout, poe, pu, pd, dom, irq;
    wire pin_seven_pkg::in_roles_t roles;
    int          bad_count = 0, samples_checked = 0, cycles = 0;
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Short debounce keeps tests quick.
    pin_seven_control #(.DEBOUNCE_CYCLES(20'h00004)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in_i(pin),
        .pad_out_o(pout), .pad_oe_o(poe), .pull_up_o(pu), .pull_down_o(pd),
        .supply_domain_o(dom), .src_i(src), .roles_o(roles), .irq_o(irq));
    pin_seven_board board (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe),
        .pull_up_i(pu), .pull_down_i(pd), .peer_oe_i(peer_oe),
        .peer_val_i(peer_val), .level_o(pin));
    task automatic complete_run();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic cycle; a low cycle comes first.
    task automatic wb(input logic [29:0] idx, input logic w,
                      input logic [15:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {16'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask
    function automatic logic [15:0] mk(input logic dir, mode, pol, od,
                                       input logic [3:0] fn);
        return {dir, ~dir, dir, mode, ~dir, pol, od, 1'b0, 1'b1, 3'h0, fn};
    endfunction
    // Moves the peer level; checks, then clears the event.
    task automatic step(input logic v, input logic e);
        peer_val <= v;
        tick(10);
        chk(irq, e);
        wb(CLR, 1'b1, 16'h1);
    endtask
    task automatic t_reset();
        chk({pd, pu}, 2'b10);
        wb(CTL, 1'b0, 16'h0);
        chk(q, pin_seven_pkg::CTRL_RESET);
        wb(ENA, 1'b0, 16'h0);
        chk(q, 32'h0);
        wb(30'h0000_0005, 1'b1, 16'hffff);
        wb(30'h0000_0005, 1'b0, 16'h0);
        chk(q, 32'h0);
        wb(CTL, 1'b1, 16'h8170);
        chk({pd, pu}, 2'b00);
        wb(CTL, 1'b0, 16'h0);
        chk(q, 32'h8000);
    endtask
    task automatic t_outputs();
        logic [3:0] f;
        logic       r;
        wb(DAT, 1'b1, 16'h1);
        for (int i = 0; i < 16; i++) begin
            f = 4'(i);
            r = f inside {[4'h5:4'h7]};
            wb(CTL, 1'b1, mk(1'b0, 1'b0, 1'b1, 1'b0, f));
            src <= '1;
            tick(3);
            chk({poe, pout}, {1'b1, !r});
            src <= '0;
            tick(3);
            chk(pout, f == 4'h0);
        end
        wb(CTL, 1'b1, mk(1'b0, 1'b0, 1'b0, 1'b0, 4'h6));
        tick(3);
        chk(pout, 1'b1);
    endtask
    task automatic t_drive();
        wb(CTL, 1'b1, mk(1'b0, 1'b0, 1'b1, 1'b1, 4'h0));
        tick(3);
        chk({poe, pin}, 2'b01);
        wb(DAT, 1'b1, 16'h0);
        tick(3);
        chk({poe, pout, pin}, 3'b100);
        wb(CTL, 1'b1, 16'h4000);
        tick(3);
        chk(poe, 1'b0);
    endtask
    task automatic t_irq();
        peer_oe <= 1'b1;
        wb(CTL, 1'b1, mk(1'b1, 1'b0, 1'b1, 1'b0, 4'h7));
        wb(CLR, 1'b1, 16'h1);
        wb(ENA, 1'b1, 16'h1);
        step(1'b1, 1'b1);
        chk(roles.watchdog_reset, 1'b1);
        step(1'b0, 1'b0);
        wb(CTL, 1'b1, mk(1'b1, 1'b1, 1'b1, 1'b0, 4'h7));
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        peer_val <= 1'b1;
        tick(1);
        step(1'b0, 1'b0);
        wb(ENA, 1'b1, 16'h0);
        peer_val <= 1'b1;
        tick(10);
        chk(irq, 1'b0);
        wb(STA, 1'b0, 16'h0);
        chk(q, 32'h1);
        wb(ENA, 1'b1, 16'h1);
        tick(2);
        chk(irq, 1'b1);
        wb(CTL, 1'b1, mk(1'b1, 1'b0, 1'b0, 1'b0, 4'h7));
        wb(CLR, 1'b1, 16'h1);
        step(1'b0, 1'b1);
        chk(roles.watchdog_reset, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic t_roles();
        wb(CTL, 1'b1, mk(1'b1, 1'b0, 1'b1, 1'b0, 4'h0));
        for (int i = 0; i < 16; i++) begin
            wb(CTL, 1'b1, mk(1'b1, 1'b0, 1'b1, 1'b0, 4'(i)));
            tick(16);
            chk(roles, i < 2 ? 11'h0 : 11'h1 << RB[i]);
            wb(DAT, 1'b0, 16'h0);
            chk(q[1], 1'b1);
        end
    endtask
    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_outputs();
        t_drive();
        t_irq();
        t_roles();
        complete_run();
    end
endmodule
bind pin_seven_control pin_seven_sva sva (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
    .supply_domain_o(supply_domain_o), .src_i(src_i), .roles_o(roles_o),
    .irq_o(irq_o));
